// ==== tmr_map.vh ====
// register map, field positions, mode codes and fixed values of the 8-bit timer
// assumes inclusion by bare name from every timer design file
`ifndef TMR_MAP_VH
`define TMR_MAP_VH

// register byte offsets
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_COUNT 8'h04
`define TMR_OFS_CMP 8'h08
`define TMR_OFS_FLAGS 8'h0C
`define TMR_OFS_STAT 8'h10

// control register fields
`define TMR_CTRL_WGM 1:0
`define TMR_CTRL_COM 3:2
`define TMR_CTRL_CS 6:4
`define TMR_CTRL_FOC 7
`define TMR_CTRL_DIR 8
`define TMR_CTRL_RST 9'h000

// flag and status fields
`define TMR_FLG_OVF 0
`define TMR_FLG_CMF 1
`define TMR_STAT_OC 0
`define TMR_STAT_DOWN 1
`define TMR_STAT_OCR 15:8

// byte lanes
`define TMR_LANE0 7:0
`define TMR_LANE1 15:8
`define TMR_LANE1_HI 8:8

// waveform modes
`define TMR_WGM_NORMAL 2'h0
`define TMR_WGM_PHASE 2'h1
`define TMR_WGM_CTC 2'h2
`define TMR_WGM_FAST 2'h3

// compare output modes
`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3

// counter values
`define TMR_CNT_BOTTOM 8'h00
`define TMR_CNT_ONE 8'h01
`define TMR_CNT_MAX 8'hFF
`define TMR_CNT_BELOW_MAX 8'hFE
`define TMR_CS_STOP 3'h0

// bus answers
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2
`define TMR_ZERO32 32'h00000000

`endif

// ==== tmr_cmp.v ====
// compare value store: software buffer, active compare value, match detect, match blocking
// assumes the timer top feeds it the live count, direction, tick and decoded writes
`timescale 1ns/1ps
`include "tmr_map.vh"

module tmr_cmp (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // timer state
    input wire tick,
    input wire [1:0] wgm,
    input wire [7:0] count,
    input wire down,
    // software writes
    input wire cmp_wr,
    input wire [7:0] cmp_wdata,
    input wire cnt_wr,
    // results
    output reg [7:0] buf_q,
    output reg [7:0] ocr_q,
    output wire match
);
    reg blk_q;
    wire pwm;
    wire at_max;
    wire load;

    assign pwm = (wgm == `TMR_WGM_PHASE) || (wgm == `TMR_WGM_FAST);
    assign at_max = tick && (count == `TMR_CNT_MAX);
    // phase-correct loads at the top while rising, fast loads as it rolls to zero
    assign load = at_max && ((wgm == `TMR_WGM_FAST) || !down);
    assign match = (count == ocr_q) && !blk_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            buf_q <= `TMR_CNT_BOTTOM;
            ocr_q <= `TMR_CNT_BOTTOM;
            blk_q <= 1'b0;
        end else begin
            if (cmp_wr) begin
                buf_q <= cmp_wdata;
            end
            if (cmp_wr && !pwm) begin
                ocr_q <= cmp_wdata;
            end else if (pwm && load) begin
                ocr_q <= buf_q;
            end
            // a count write hides the match of the next tick, even while stopped
            if (cnt_wr) begin
                blk_q <= 1'b1;
            end else if (tick) begin
                blk_q <= 1'b0;
            end
        end
    end
endmodule

// ==== tmr_wavegen.v ====
// compare output state: set, clear, toggle and PWM extreme-value handling
// assumes match is already blocked after count writes and force is a one-cycle strobe
`timescale 1ns/1ps
`include "tmr_map.vh"

module tmr_wavegen (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // timer state
    input wire tick,
    input wire [1:0] wgm,
    input wire [1:0] com,
    input wire match,
    input wire force_cmp,
    input wire [7:0] count,
    input wire [7:0] ocr,
    input wire down,
    // output state
    output reg oc_q
);
    reg oc_d;
    reg lvl;
    wire roll;
    wire up_eff;
    wire hit;

    assign roll = tick && (count == `TMR_CNT_MAX);
    // the bottom tick counts as rising so a zero compare keeps the output low
    assign up_eff = !down || (count == `TMR_CNT_BOTTOM);
    assign hit = tick && match;

    always @* begin
        oc_d = oc_q;
        lvl = 1'b0;
        case (wgm)
            `TMR_WGM_NORMAL, `TMR_WGM_CTC: begin
                if (hit || force_cmp) begin
                    case (com)
                        `TMR_COM_TOGGLE: oc_d = ~oc_q;
                        `TMR_COM_CLEAR: oc_d = 1'b0;
                        `TMR_COM_SET: oc_d = 1'b1;
                        default: oc_d = oc_q;
                    endcase
                end
            end
            `TMR_WGM_FAST: begin
                if (com == `TMR_COM_TOGGLE) begin
                    if (hit) begin
                        oc_d = ~oc_q;
                    end
                end else if (com != `TMR_COM_OFF) begin
                    // a compare at max is ignored so the level stays constant
                    if (hit && (ocr != `TMR_CNT_MAX)) begin
                        oc_d = (com == `TMR_COM_SET);
                    end else if (roll) begin
                        oc_d = (com == `TMR_COM_CLEAR);
                    end
                end
            end
            `TMR_WGM_PHASE: begin
                if (com[1]) begin
                    if (roll && !down) begin
                        // at the top show the rising-match result, or set for a compare at max
                        lvl = (ocr == `TMR_CNT_MAX);
                        oc_d = (com == `TMR_COM_SET) ? ~lvl : lvl;
                    end else if (hit) begin
                        lvl = !up_eff;
                        oc_d = (com == `TMR_COM_SET) ? ~lvl : lvl;
                    end
                end
            end
            default: oc_d = oc_q;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            oc_q <= 1'b0;
        end else begin
            oc_q <= oc_d;
        end
    end
endmodule

// ==== tmr_top.v ====
// 8-bit timer/counter with one compare output, reached over AXI4-Lite
// assumes timer_tick is a prescaled enable synchronous to aclk; the pin buffer lives outside
//
// Function
// - mode 0 only counts up and wraps from 0xFF to 0x00
// - normal mode sets overflow flag as count becomes zero; counting never clears it
// - mode 2 clears the count to zero on compare match
// - clear-on-match compare is unbuffered; a value below count waits for wrap
// - clear-on-match with output mode 1 toggles the output each match
// - clear-on-match sets overflow flag when count passes max to zero
// - mode 3 counts zero to max then clears on the next tick
// - fast PWM mode 2 clears on match, sets at roll; mode 3 inverse
// - fast PWM sets overflow flag each time count rolls from max to zero
// - fast PWM compare zero gives one-tick spike, compare max constant level
// - fast PWM output mode 1 toggles on match, compare still buffered
// - mode 1 counts up, holds max one tick, counts down to zero
// - phase PWM clears on rising match, sets on falling match; inverted opposite
// - phase PWM sets overflow flag each time count reaches zero
// - phase PWM compare zero gives constant low, max constant high
// - phase PWM output at max equals rising-match result
// - output reaches pin only while direction selects output
// - PWM writes go to buffer, loaded to compare at top or bottom
// - compare flag set on the tick after count equals compare
// - count write blocks the next tick's compare match, even when stopped
// - clock source zero stops counting; software write beats count or clear
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tmr_map.vh"

module tmr_top (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address channel
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read address channel
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // prescaled timer enable
    input wire timer_tick,
    // compare output pin
    output reg compare_output_o,
    output reg compare_output_oe
);
    // write channel holding
    reg aw_held_q;
    reg [7:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire rd_take;

    // decoded writes
    wire wr_ctrl;
    wire wr_count;
    wire wr_cmp;
    wire wr_flags;
    wire wr_known;

    // control fields
    reg [8:0] ctrl_q;
    wire [1:0] waveform_mode_sel;
    wire [1:0] compare_output_mode;
    wire [2:0] clock_source_sel;
    wire pin_dir;
    reg force_q;

    // counter state
    reg [7:0] count_value_q;
    reg [7:0] count_value_d;
    reg down_q;
    reg down_d;
    reg ovf_cond;
    reg overflow_flag_q;
    reg compare_match_flag_q;
    wire tick;
    wire match;
    wire oc_state;
    wire [7:0] cmp_buf;
    wire [7:0] compare_value;
    reg [31:0] rd_word;
    reg rd_known;

    assign waveform_mode_sel = ctrl_q[`TMR_CTRL_WGM];
    assign compare_output_mode = ctrl_q[`TMR_CTRL_COM];
    assign clock_source_sel = ctrl_q[`TMR_CTRL_CS];
    assign pin_dir = ctrl_q[`TMR_CTRL_DIR];

    assign tick = timer_tick && (clock_source_sel != `TMR_CS_STOP);

    // ---- AXI4-Lite write path: address and data taken in either order ----
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    assign wr_ctrl = wr_fire && (aw_addr_q == `TMR_OFS_CTRL);
    assign wr_count = wr_fire && (aw_addr_q == `TMR_OFS_COUNT) && w_strb_q[0];
    assign wr_cmp = wr_fire && (aw_addr_q == `TMR_OFS_CMP) && w_strb_q[0];
    assign wr_flags = wr_fire && (aw_addr_q == `TMR_OFS_FLAGS) && w_strb_q[0];
    assign wr_known = (aw_addr_q == `TMR_OFS_CTRL) || (aw_addr_q == `TMR_OFS_COUNT) ||
                      (aw_addr_q == `TMR_OFS_CMP) || (aw_addr_q == `TMR_OFS_FLAGS) ||
                      (aw_addr_q == `TMR_OFS_STAT);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMR_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= `TMR_OFS_CTRL;
            w_data_q <= `TMR_ZERO32;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr & 8'hFC;
                s_axi_awready <= 1'b0;
            end else if (!aw_held_q && !s_axi_bvalid && !wr_fire) begin
                s_axi_awready <= 1'b1;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_held_q && !s_axi_bvalid && !wr_fire) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---- AXI4-Lite read path ----
    assign rd_take = s_axi_arvalid && s_axi_arready;

    always @* begin
        rd_word = `TMR_ZERO32;
        rd_known = 1'b1;
        case (s_axi_araddr & 8'hFC)
            `TMR_OFS_CTRL: begin
                // the force strobe always reads as zero
                rd_word[8:0] = ctrl_q;
            end
            `TMR_OFS_COUNT: begin
                rd_word[`TMR_LANE0] = count_value_q;
            end
            `TMR_OFS_CMP: begin
                rd_word[`TMR_LANE0] = cmp_buf;
            end
            `TMR_OFS_FLAGS: begin
                rd_word[`TMR_FLG_OVF] = overflow_flag_q;
                rd_word[`TMR_FLG_CMF] = compare_match_flag_q;
            end
            `TMR_OFS_STAT: begin
                rd_word[`TMR_STAT_OC] = oc_state;
                rd_word[`TMR_STAT_DOWN] = down_q;
                rd_word[`TMR_STAT_OCR] = compare_value;
            end
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `TMR_ZERO32;
            s_axi_rresp <= `TMR_RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_known ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ---- control register and force strobe ----
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `TMR_CTRL_RST;
            force_q <= 1'b0;
        end else begin
            force_q <= 1'b0;
            if (wr_ctrl) begin
                if (w_strb_q[0]) begin
                    ctrl_q[`TMR_LANE0] <= w_data_q[`TMR_LANE0];
                    ctrl_q[`TMR_CTRL_FOC] <= 1'b0;
                    // forcing only acts in the non-PWM modes
                    force_q <= w_data_q[`TMR_CTRL_FOC] && !w_data_q[0];
                end
                if (w_strb_q[1]) begin
                    ctrl_q[`TMR_CTRL_DIR] <= w_data_q[`TMR_CTRL_DIR];
                end
            end
        end
    end

    // ---- counting sequence ----
    always @* begin
        count_value_d = count_value_q;
        down_d = down_q;
        ovf_cond = 1'b0;
        if (wr_count) begin
            // software write wins over any count or clear in the same cycle
            count_value_d = w_data_q[`TMR_LANE0];
        end else if (tick) begin
            case (waveform_mode_sel)
                `TMR_WGM_NORMAL: begin
                    count_value_d = count_value_q + `TMR_CNT_ONE;
                    ovf_cond = (count_value_q == `TMR_CNT_MAX);
                end
                `TMR_WGM_CTC: begin
                    if (match) begin
                        count_value_d = `TMR_CNT_BOTTOM;
                    end else begin
                        count_value_d = count_value_q + `TMR_CNT_ONE;
                    end
                    ovf_cond = (count_value_q == `TMR_CNT_MAX);
                end
                `TMR_WGM_FAST: begin
                    if (count_value_q == `TMR_CNT_MAX) begin
                        count_value_d = `TMR_CNT_BOTTOM;
                    end else begin
                        count_value_d = count_value_q + `TMR_CNT_ONE;
                    end
                    ovf_cond = (count_value_q == `TMR_CNT_MAX);
                end
                `TMR_WGM_PHASE: begin
                    // max and zero are each held for one tick at the turn
                    if (!down_q && (count_value_q == `TMR_CNT_MAX)) begin
                        down_d = 1'b1;
                        count_value_d = `TMR_CNT_BELOW_MAX;
                    end else if (down_q && (count_value_q == `TMR_CNT_BOTTOM)) begin
                        down_d = 1'b0;
                        count_value_d = `TMR_CNT_ONE;
                    end else if (down_q) begin
                        count_value_d = count_value_q - `TMR_CNT_ONE;
                    end else begin
                        count_value_d = count_value_q + `TMR_CNT_ONE;
                    end
                    ovf_cond = down_q && (count_value_q == `TMR_CNT_ONE);
                end
                default: begin
                    count_value_d = count_value_q;
                end
            endcase
        end
        // the other modes only count up
        if (waveform_mode_sel != `TMR_WGM_PHASE) begin
            down_d = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_value_q <= `TMR_CNT_BOTTOM;
            down_q <= 1'b0;
        end else begin
            count_value_q <= count_value_d;
            down_q <= down_d;
        end
    end

    // ---- flags: hardware set beats a same-cycle write-one clear ----
    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_q <= 1'b0;
            compare_match_flag_q <= 1'b0;
        end else begin
            if (tick && ovf_cond) begin
                overflow_flag_q <= 1'b1;
            end else if (wr_flags && w_data_q[`TMR_FLG_OVF]) begin
                overflow_flag_q <= 1'b0;
            end
            if (tick && match) begin
                compare_match_flag_q <= 1'b1;
            end else if (wr_flags && w_data_q[`TMR_FLG_CMF]) begin
                compare_match_flag_q <= 1'b0;
            end
        end
    end

    // ---- compare unit and waveform ----
    tmr_cmp u_cmp (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .wgm(waveform_mode_sel),
        .count(count_value_q),
        .down(down_q),
        .cmp_wr(wr_cmp),
        .cmp_wdata(w_data_q[`TMR_LANE0]),
        .cnt_wr(wr_count),
        .buf_q(cmp_buf),
        .ocr_q(compare_value),
        .match(match)
    );

    tmr_wavegen u_wave (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .wgm(waveform_mode_sel),
        .com(compare_output_mode),
        .match(match),
        .force_cmp(force_q),
        .count(count_value_q),
        .ocr(compare_value),
        .down(down_q),
        .oc_q(oc_state)
    );

    // ---- pin: internal state is kept even while the pin is not driven ----
    always @(posedge aclk) begin
        if (!aresetn) begin
            compare_output_o <= 1'b0;
            compare_output_oe <= 1'b0;
        end else begin
            compare_output_o <= oc_state;
            compare_output_oe <= pin_dir && (compare_output_mode != `TMR_COM_OFF);
        end
    end
endmodule

// ==== tmr_chk_asserts.sv ====
// timer port assertions: bus handshakes and pin timing
// assumes binding onto tmr_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "tmr_map.vh"

module tmr_chk (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write side
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // read side
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // tick and pin
    input wire timer_tick,
    input wire compare_output_o,
    input wire compare_output_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_take = s_axi_arvalid && s_axi_arready;

    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read late");
    a_read_rearm: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("no arready");
    a_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("bvalid late");
    a_write_unmapped: assert property (wr_take && s_axi_awaddr > 8'h13 |-> ##2 s_axi_bresp == `TMR_RESP_SLVERR)
        else $error("bad write ok");
    a_read_unmapped: assert property (rd_take && s_axi_araddr > 8'h13 |=> s_axi_rresp == `TMR_RESP_SLVERR
        && s_axi_rdata == `TMR_ZERO32)
        else $error("bad read ok");
    a_read_mapped: assert property (rd_take && s_axi_araddr < 8'h14 |=> s_axi_rresp == `TMR_RESP_OKAY)
        else $error("mapped read refused");
    // the pin lags its state by a clock
    a_pin_on_tick: assert property ($changed(compare_output_o) |-> $past(timer_tick, 2)
        || $past(s_axi_bvalid) || s_axi_bvalid)
        else $error("pin moved untimed");
    a_oe_on_write: assert property ($changed(compare_output_oe) |-> $past(s_axi_bvalid) || s_axi_bvalid)
        else $error("oe moved untimed");

    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `TMR_RESP_SLVERR);
    c_pin_rise: cover property ($rose(compare_output_o));
    c_oe_rise: cover property ($rose(compare_output_oe));
endmodule

bind tmr_top tmr_chk u_chk (.*);

// ==== tb.sv ====
// timer bench: bus tasks, stepped ticks, a test per mode
// assumes tmr_top and its bound checker; single-pulse ticks keep reads still
`timescale 1ns/1ps
`include "tmr_map.vh"

module tb;
    reg aclk = 0;
    reg aresetn = 0;
    reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, c, v;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, timer_tick = 0;
    reg [31:0] s_axi_wdata = 0, q;
    reg [1:0] r;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_o, pin_oe;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer mismatches = 0, tests_run = 0, k, m;

    tmr_top dut (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hF), .s_axi_arprot(3'h0), .compare_output_o(pin_o),
        .compare_output_oe(pin_oe));

    initial begin
        forever #5 aclk = ~aclk;
    end

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp, input string what);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
            end
        end
    endtask

    function [1:0] resp_of(input [7:0] a);
        resp_of = (a > 8'h13) ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
    endfunction

    // pin set to output
    function [31:0] ctrl(input [1:0] w, input [1:0] cm, input [2:0] cs);
        ctrl = {23'h0, 1'b1, 1'b0, cs, cm, w};
    endfunction

    // fast pwm level, inverted for mode three
    function fl(input [1:0] cm, input mt);
        fl = mt ~^ (cm == `TMR_COM_SET);
    endfunction

    task xfer(input wr, input [7:0] a, input [31:0] d);
        integer i;
        reg done;
        begin
            done = 0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= wr;
            s_axi_wvalid <= wr;
            s_axi_bready <= wr;
            s_axi_arvalid <= !wr;
            s_axi_rready <= !wr;
            for (i = 0; i < 40 && !done; i = i + 1) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wready) s_axi_wvalid <= 0;
                if (s_axi_arready) s_axi_arvalid <= 0;
                if ((s_axi_bvalid && wr) || (s_axi_rvalid && !wr)) begin
                    done = 1;
                    q = s_axi_rdata;
                    r = wr ? s_axi_bresp : s_axi_rresp;
                    s_axi_bready <= 0;
                    s_axi_rready <= 0;
                end
            end
            if (!done) begin
                chk(0, 1, "bus timeout");
                print_verdict;
            end else chk(r, resp_of(a), "bus response");
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        xfer(1, a, d);
    endtask

    task rd(input [7:0] a, input [31:0] exp, input string what);
        begin
            xfer(0, a, 0);
            chk(q, exp, what);
        end
    endtask

    task ticks(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge aclk);
                timer_tick <= 1;
                @(posedge aclk);
                timer_tick <= 0;
            end
        end
    endtask

    initial begin
        k = $urandom(32'hF92A1D36);
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        for (c = 0; c < 8'h18; c = c + 4) rd(c, 0, "reset value");
        wr(8'h20, 32'hFFFFFFFF);
        $display("test reset done");
        wr(`TMR_OFS_CTRL, ctrl(`TMR_WGM_NORMAL, `TMR_COM_OFF, `TMR_CS_STOP));
        wr(`TMR_OFS_COUNT, 32'hFE);
        ticks(3);
        rd(`TMR_OFS_COUNT, 32'hFE, "stopped count");
        wr(`TMR_OFS_CTRL, ctrl(`TMR_WGM_NORMAL, `TMR_COM_OFF, 3'(1 + $urandom % 7)));
        ticks(1);
        rd(`TMR_OFS_COUNT, 32'hFF, "normal max");
        rd(`TMR_OFS_FLAGS, 0, "early overflow");
        ticks(1);
        rd(`TMR_OFS_COUNT, 0, "normal wrap");
        rd(`TMR_OFS_FLAGS, 1, "overflow at zero");
        ticks(1);
        rd(`TMR_OFS_FLAGS, 3, "match at zero");
        chk(pin_oe, 0, "pin off");
        $display("test normal done");
        c = 8'(8'h10 + $urandom % 8'h30);
        wr(`TMR_OFS_CTRL, ctrl(`TMR_WGM_CTC, `TMR_COM_TOGGLE, 3'h1));
        wr(`TMR_OFS_CMP, c);
        wr(`TMR_OFS_COUNT, 0);
        wr(`TMR_OFS_FLAGS, 3);
        ticks(c);
        rd(`TMR_OFS_COUNT, c, "ctc top");
        ticks(1);
        rd(`TMR_OFS_COUNT, 0, "ctc clear");
        rd(`TMR_OFS_FLAGS, 2, "match flag");
        rd(`TMR_OFS_STAT, {16'h0, c, 8'h01}, "ctc toggle");
        chk({pin_oe, pin_o}, 2'b11, "pin driven");
        ticks(c + 1);
        rd(`TMR_OFS_STAT, {16'h0, c, 8'h00}, "ctc toggle back");
        wr(`TMR_OFS_FLAGS, 3);
        wr(`TMR_OFS_COUNT, c);
        ticks(1);
        rd(`TMR_OFS_COUNT, c + 1, "blocked match");
        wr(`TMR_OFS_COUNT, 32'hFE);
        ticks(2);
        rd(`TMR_OFS_COUNT, 0, "missed top wraps");
        rd(`TMR_OFS_FLAGS, 1, "ctc overflow");
        wr(`TMR_OFS_CTRL, ctrl(`TMR_WGM_CTC, `TMR_COM_TOGGLE, 3'h1) & 32'hFFFFFEFF);
        @(negedge aclk);
        chk(pin_oe, 0, "pin released");
        $display("test ctc done");
        for (m = 2; m < 4; m = m + 1) begin
            v = 8'(8'h40 + $urandom % 8'h80);
            wr(`TMR_OFS_CTRL, ctrl(`TMR_WGM_FAST, 2'(m), 3'h1));
            wr(`TMR_OFS_CMP, v);
            wr(`TMR_OFS_COUNT, 32'hFE);
            wr(`TMR_OFS_FLAGS, 3);
            xfer(0, `TMR_OFS_STAT, 0);
            chk(q[15:8], c, "buffered");
            ticks(2);
            rd(`TMR_OFS_COUNT, 0, "fast roll");
            rd(`TMR_OFS_FLAGS, 1, "fast overflow");
            rd(`TMR_OFS_STAT, {16'h0, v, 7'h0, fl(2'(m), 0)}, "fast bottom");
            wr(`TMR_OFS_COUNT, v - 1);
            ticks(2);
            xfer(0, `TMR_OFS_STAT, 0);
            chk(q[0], fl(2'(m), 1), "fast match");
            rd(`TMR_OFS_FLAGS, 3, "fast match flag");
            c = v;
        end
        $display("test fast done");
        v = 8'(8'h40 + $urandom % 8'h80);
        wr(`TMR_OFS_CTRL, ctrl(`TMR_WGM_PHASE, `TMR_COM_CLEAR, 3'h1));
        wr(`TMR_OFS_CMP, v);
        wr(`TMR_OFS_COUNT, 32'hFE);
        ticks(1);
        rd(`TMR_OFS_COUNT, 32'hFF, "phase max");
        ticks(1);
        rd(`TMR_OFS_COUNT, 32'hFE, "phase turn");
        rd(`TMR_OFS_STAT, {16'h0, v, 8'h02}, "phase top");
        wr(`TMR_OFS_COUNT, v + 1);
        ticks(2);
        xfer(0, `TMR_OFS_STAT, 0);
        chk(q[1:0], 2'b11, "phase down match");
        wr(`TMR_OFS_FLAGS, 3);
        wr(`TMR_OFS_COUNT, 32'h02);
        ticks(2);
        rd(`TMR_OFS_COUNT, 0, "phase bottom");
        rd(`TMR_OFS_FLAGS, 1, "phase overflow");
        ticks(1);
        wr(`TMR_OFS_COUNT, v - 1);
        ticks(2);
        xfer(0, `TMR_OFS_STAT, 0);
        chk(q[1:0], 2'b00, "phase up match");
        $display("test phase done");
        print_verdict;
    end
endmodule
